// ---- sflf_cfg.svh ----
/*
 * constants of the serial flash lane front end: opcodes, array geometry
 * field positions, phase lengths and reset values.
 * assumes: included by bare name from the front end.
 */
`ifndef SFLF_CFG_SVH
`define SFLF_CFG_SVH

// array geometry: bit positions inside the 24-bit byte address
`define SFLF_ADDR_BITS      24
`define SFLF_ARRAY_TOP      22
`define SFLF_SECTOR_LSB     12
`define SFLF_HALF_LSB       15
`define SFLF_BLOCK_LSB      16
`define SFLF_BIG_LSB        20
`define SFLF_LAST_SECTOR    11'h07_FF

// quad enable bit position inside the second status register
`define SFLF_QE_BIT         1

// opcodes that choose lane widths
`define SFLF_OP_READ        8'h03
`define SFLF_OP_DUAL_OUT    8'h3B
`define SFLF_OP_DUAL_IO     8'hBB
`define SFLF_OP_DUAL_ID     8'h92
`define SFLF_OP_QUAD_OUT    8'h6B
`define SFLF_OP_QUAD_IO     8'hEB
`define SFLF_OP_QUAD_WORD   8'hE7
`define SFLF_OP_QUAD_ID     8'h94
`define SFLF_OP_QUAD_PROG   8'h32

// phase lengths in serial clocks or bits
`define SFLF_CMD_LAST       5'h07
`define SFLF_DUMMY_LAST     5'h07
`define SFLF_BYTE_BITS      5'h08

// reset values
`define SFLF_RST_BYTE       8'h00
`define SFLF_RST_ADDR       24'h00_0000
`define SFLF_IDLE_BYTE      8'hFF

`endif

// ---- sflf_pkg.sv ----
/*
 * types shared by the serial flash lane front end.
 * assumes: sflf_cfg.svh sits in the same folder.
 */
`default_nettype none

package sflf_pkg;
	// lane width; the code is also the number of bits per serial clock
	typedef enum logic [2:0] {
		SFLF_W1 = 3'h1,
		SFLF_W2 = 3'h2,
		SFLF_W4 = 3'h4
	} sflf_width_t;

	// link phase, one-hot
	typedef enum logic [4:0] {
		SFLF_ST_CMD    = 5'h01,
		SFLF_ST_ADDR   = 5'h02,
		SFLF_ST_DUMMY  = 5'h04,
		SFLF_ST_DATA   = 5'h08,
		SFLF_ST_IGNORE = 5'h10
	} sflf_state_t;
endpackage : sflf_pkg

`default_nettype wire

// ---- sflf_fifo.sv ----
/*
 * first-in first-out buffer with valid/ready on both sides.
 * assumes: one clock, asynchronous active-high reset, depth a power of two.
 */
`timescale 1ns/1ps
`default_nettype none

module sflf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             s_valid,
	output logic                  s_ready,
	input  wire logic [WIDTH-1:0] s_data,
	output logic                  m_valid,
	input  wire logic             m_ready,
	output logic      [WIDTH-1:0] m_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_ff;
	logic [AW-1:0]    rp_ff;
	logic [AW:0]      cnt_ff;
	wire              push;
	wire              pop;

	// honest flags straight from the fill count
	assign s_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign m_valid = (cnt_ff != '0);
	assign push    = s_valid & s_ready;
	assign pop     = m_valid & m_ready;
	assign m_data  = mem[rp_ff];

	// storage has no reset; only pointers and the fill count carry state
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp_ff] <= s_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff  <= wp_ff + AW'(push);
			rp_ff  <= rp_ff + AW'(pop);
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	default clocking fcb @(posedge clock); endclocking
	default disable iff (rst);

	a_full_refuses: assert property (cnt_ff == (AW+1)'(DEPTH) |-> !s_ready)
		else $error("fifo accepts while full");
	a_count_moves: assert property (push && !pop |=> cnt_ff == $past(cnt_ff) + 1)
		else $error("fifo count missed a push");
	c_fifo_fills: cover property (!s_ready ##1 s_ready);
endmodule : sflf_fifo

`default_nettype wire

// ---- sflf_frontend.sv ----
/*
 * serial flash lane front end: decodes opcode, address and lane widths
 * on the serial clock and hands headers and written bytes across to the
 * core clock domain, and read bytes back from it.
 * assumes: core clock 40 MHz, serial clock at most 1/64 ns in quad data
 * phases; the pad ring resolves lanes from drive and enable signals.
 */
// What this block does
// - address space splits into 4 KB sectors, last is 7FF000h-7FFFFFh
// - sectors group into 64 KB blocks, each split into 32 KB halves
// - the array also groups into eight 8 Mbit big blocks
// - serial clock modes 0 and 3 both work without configuration
// - inputs sampled on rising edge, outputs change after falling edge
// - only 3Bh, BBh and 92h run two lanes
// - in two-lane work lanes zero and one are bidirectional
// - 6Bh, EBh and E7h run four lanes
// - 94h and 32h also run four lanes
// - in four-lane work lanes two and three join as bidirectional
// - four-lane opcodes are honoured only with quad enable set
// - after power-up a chip select falling edge is needed first
// - while power-on reset is active every instruction is ignored
// - below power-fail threshold the device resets at once
// - quad enable is bit one of second status register; disables protect
// - chip select high ignores inputs and floats all outputs
`timescale 1ns/1ps
`default_nettype none
`include "sflf_cfg.svh"

module sflf_frontend
	import sflf_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        power_fail,
	input  wire logic [7:0]  second_status_register,
	input  wire logic        serial_clock,
	input  wire logic        chip_select_n,
	input  wire logic        data_lane_zero_level,
	output logic             data_lane_zero_drive,
	output logic             data_lane_zero_oe,
	input  wire logic        data_lane_one_level,
	output logic             data_lane_one_drive,
	output logic             data_lane_one_oe,
	input  wire logic        data_lane_two_level,
	output logic             data_lane_two_drive,
	output logic             data_lane_two_oe,
	input  wire logic        data_lane_three_level,
	output logic             data_lane_three_drive,
	output logic             data_lane_three_oe,
	output logic             write_protect_active,
	output logic             instr_valid,
	output logic [7:0]       instr_code,
	output logic [23:0]      instr_addr,
	output logic [2:0]       instr_addr_lanes,
	output logic [2:0]       instr_data_lanes,
	output logic             instr_is_read,
	output logic [10:0]      sector_index,
	output logic [7:0]       half_block_index,
	output logic [6:0]       block_index,
	output logic [2:0]       big_block_index,
	output logic             addr_out_of_range,
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic [7:0]       wr_data,
	output logic             wr_overrun,
	input  wire logic        rd_valid,
	output logic             rd_ready,
	input  wire logic [7:0]  rd_data
);
	// serial clock domain registers
	sflf_state_t state_ff;
	sflf_state_t nxt_state;
	logic [4:0]  cnt_ff;
	logic [4:0]  nxt_cnt;
	logic [7:0]  cmd_ff;
	logic [23:0] addr_ff;
	logic [7:0]  wsh_ff;
	logic [7:0]  wbyte_ff;
	logic        hdr_tgl_ff;
	logic        wb_tgl_ff;
	logic        rd_tgl_ff;
	logic [7:0]  osh_ff;
	logic [4:0]  ocnt_ff;
	logic        oe_ff;
	logic [2:0]  qe_sync_ff;
	// core clock domain registers
	logic [5:0]  s1_ff;
	logic [5:0]  s2_ff;
	logic [5:0]  s3_ff;
	logic [5:0]  seen_ff;
	logic        armed_ff;
	logic        pend_ff;
	logic [7:0]  pend_byte_ff;
	logic [7:0]  rd_hold_ff;
	logic        rd_full_ff;
	logic        hdr_valid_ff;
	logic [7:0]  hdr_cmd_ff;
	logic [23:0] hdr_addr_ff;
	logic        overrun_ff;

	// quad enable and the write-protect function it replaces
	wire quad_enable_bit = second_status_register[`SFLF_QE_BIT];
	assign write_protect_active = ~quad_enable_bit & ~seen_ff[2];

	// the link logic is held in reset whenever deselected, not yet armed,
	// in power-on reset or below the power-fail threshold
	wire link_rst = chip_select_n | rst | power_fail | ~armed_ff;

	// opcode decode on the byte completing at this edge
	wire [3:0] lanes_in = {data_lane_three_level, data_lane_two_level,
		data_lane_one_level, data_lane_zero_level};
	wire [7:0] nxt_op   = {cmd_ff[6:0], lanes_in[0]};
	wire op_dual_addr = (nxt_op == `SFLF_OP_DUAL_IO) |
		(nxt_op == `SFLF_OP_DUAL_ID);
	wire op_dual_data = op_dual_addr | (nxt_op == `SFLF_OP_DUAL_OUT);
	wire op_quad_addr = (nxt_op == `SFLF_OP_QUAD_IO) |
		(nxt_op == `SFLF_OP_QUAD_WORD) | (nxt_op == `SFLF_OP_QUAD_ID);
	wire op_quad_data = op_quad_addr | (nxt_op == `SFLF_OP_QUAD_OUT) |
		(nxt_op == `SFLF_OP_QUAD_PROG);
	wire op_read      = (op_dual_data | op_quad_data |
		(nxt_op == `SFLF_OP_READ)) & (nxt_op != `SFLF_OP_QUAD_PROG);
	wire qe_link      = qe_sync_ff[1] & qe_sync_ff[2];

	// widths held by the decoded opcode in cmd_ff for later phases
	wire cur_dual_a = (cmd_ff == `SFLF_OP_DUAL_IO) | (cmd_ff == `SFLF_OP_DUAL_ID);
	wire cur_quad_a = (cmd_ff == `SFLF_OP_QUAD_IO) |
		(cmd_ff == `SFLF_OP_QUAD_WORD) | (cmd_ff == `SFLF_OP_QUAD_ID);
	wire cur_dual_d = cur_dual_a | (cmd_ff == `SFLF_OP_DUAL_OUT);
	wire cur_quad_d = cur_quad_a | (cmd_ff == `SFLF_OP_QUAD_OUT) |
		(cmd_ff == `SFLF_OP_QUAD_PROG);
	wire cur_read   = (cur_dual_d | cur_quad_d | (cmd_ff == `SFLF_OP_READ)) &
		(cmd_ff != `SFLF_OP_QUAD_PROG);
	sflf_width_t aw;
	sflf_width_t dw;
	assign aw = cur_quad_a ? SFLF_W4 : (cur_dual_a ? SFLF_W2 : SFLF_W1);
	assign dw = cur_quad_d ? SFLF_W4 : (cur_dual_d ? SFLF_W2 : SFLF_W1);
	wire [4:0] aw5 = {2'h0, aw};
	wire [4:0] dw5 = {2'h0, dw};

	// msb-first shift on the active lanes, lane one above lane zero
	wire [23:0] nxt_addr = cur_quad_a ? {addr_ff[19:0], lanes_in} :
		cur_dual_a ? {addr_ff[21:0], lanes_in[1:0]} :
		{addr_ff[22:0], lanes_in[0]};
	wire [7:0] nxt_wsh = cur_quad_d ? {wsh_ff[3:0], lanes_in} :
		cur_dual_d ? {wsh_ff[5:0], lanes_in[1:0]} :
		{wsh_ff[6:0], lanes_in[0]};
	wire addr_done = (cnt_ff + aw5) == 5'(`SFLF_ADDR_BITS);
	wire byte_done = (cnt_ff + dw5) == `SFLF_BYTE_BITS;
	wire in_st_cmd  = (state_ff == SFLF_ST_CMD);
	wire in_st_addr = (state_ff == SFLF_ST_ADDR);
	wire in_wr_data = (state_ff == SFLF_ST_DATA) & ~cur_read;

	// phase sequencing; a quad opcode without quad enable idles the frame
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + 5'h01;
		case (state_ff)
			SFLF_ST_CMD: begin
				if (cnt_ff == `SFLF_CMD_LAST) begin
					nxt_cnt   = '0;
					nxt_state = (op_quad_data & ~qe_link) ? SFLF_ST_IGNORE :
						SFLF_ST_ADDR;
				end
			end
			SFLF_ST_ADDR: begin
				nxt_cnt = cnt_ff + aw5;
				if (addr_done) begin
					nxt_cnt   = '0;
					nxt_state = cur_read ? SFLF_ST_DUMMY : SFLF_ST_DATA;
				end
			end
			SFLF_ST_DUMMY: begin
				if (cnt_ff == `SFLF_DUMMY_LAST) begin
					nxt_cnt   = '0;
					nxt_state = SFLF_ST_DATA;
				end
			end
			SFLF_ST_DATA: nxt_cnt = byte_done ? 5'h00 : cnt_ff + dw5;
			default:      nxt_cnt = '0;
		endcase
	end

	// per-frame state, cleared by deselection
	always_ff @(posedge serial_clock or posedge link_rst) begin
		if (link_rst) begin
			state_ff   <= SFLF_ST_CMD;
			cnt_ff     <= '0;
			wsh_ff     <= `SFLF_RST_BYTE;
			qe_sync_ff <= '0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			wsh_ff     <= in_wr_data ? nxt_wsh : wsh_ff;
			qe_sync_ff <= {qe_sync_ff[1:0], quad_enable_bit};
		end
	end

	// values handed across survive deselection so the core can fetch them
	always_ff @(posedge serial_clock or posedge rst) begin
		if (rst) begin
			cmd_ff     <= `SFLF_RST_BYTE;
			addr_ff    <= `SFLF_RST_ADDR;
			wbyte_ff   <= `SFLF_RST_BYTE;
			hdr_tgl_ff <= 1'b0;
			wb_tgl_ff  <= 1'b0;
		end else if (!link_rst) begin
			cmd_ff     <= in_st_cmd ? nxt_op : cmd_ff;
			addr_ff    <= in_st_addr ? nxt_addr : addr_ff;
			hdr_tgl_ff <= hdr_tgl_ff ^ (in_st_addr & addr_done);
			wbyte_ff   <= (in_wr_data & byte_done) ? nxt_wsh : wbyte_ff;
			wb_tgl_ff  <= wb_tgl_ff ^ (in_wr_data & byte_done);
		end
	end

	// outgoing data shifts on the falling edge; byte taken from the hold
	wire rd_phase = (state_ff == SFLF_ST_DATA) & cur_read;
	wire rd_load  = rd_phase & (ocnt_ff == 5'h00);
	always_ff @(negedge serial_clock or posedge link_rst) begin
		if (link_rst) begin
			osh_ff  <= `SFLF_IDLE_BYTE;
			ocnt_ff <= '0;
			oe_ff   <= 1'b0;
		end else if (rd_phase) begin
			osh_ff  <= rd_load ? rd_hold_ff : osh_ff << dw;
			ocnt_ff <= ((ocnt_ff + dw5) == `SFLF_BYTE_BITS) ? 5'h00 : ocnt_ff + dw5;
			oe_ff   <= 1'b1;
		end
	end

	// each byte taken toggles back so the core can refill the hold
	always_ff @(negedge serial_clock or posedge rst) begin
		if (rst) begin
			rd_tgl_ff <= 1'b0;
		end else if (!link_rst) begin
			rd_tgl_ff <= rd_tgl_ff ^ rd_load;
		end
	end

	// lane drivers: single on lane one, dual on one/zero, quad on all four
	assign data_lane_one_drive   = cur_quad_d ? osh_ff[5] : osh_ff[7];
	assign data_lane_zero_drive  = cur_quad_d ? osh_ff[4] : osh_ff[6];
	assign data_lane_two_drive   = osh_ff[6];
	assign data_lane_three_drive = osh_ff[7];
	assign data_lane_one_oe      = oe_ff;
	assign data_lane_zero_oe     = oe_ff & (cur_dual_d | cur_quad_d);
	assign data_lane_two_oe      = oe_ff & cur_quad_d;
	assign data_lane_three_oe    = oe_ff & cur_quad_d;

	// pin and cross-domain inputs: three flops, counted once 2 and 3 agree
	wire [5:0] async_in = {rd_tgl_ff, wb_tgl_ff, hdr_tgl_ff,
		data_lane_two_level, power_fail, chip_select_n};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_settle
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					seen_ff[gi] <= 1'b0;
				end else if (s2_ff[gi] == s3_ff[gi]) begin
					seen_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate
	wire [5:0] agreed = ~(s2_ff ^ s3_ff);
	wire hdr_evt = agreed[3] & (s3_ff[3] != seen_ff[3]);
	wire wb_evt  = agreed[4] & (s3_ff[4] != seen_ff[4]);
	wire rd_evt  = agreed[5] & (s3_ff[5] != seen_ff[5]);
	wire pf_low  = ~seen_ff[1];

	// arming needs chip select seen high; power failure disarms at once
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_ff <= 1'b0;
		end else begin
			armed_ff <= pf_low & ~power_fail & (armed_ff | seen_ff[0]);
		end
	end

	// header capture; data stays until the next header
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hdr_valid_ff <= 1'b0;
			hdr_cmd_ff   <= `SFLF_RST_BYTE;
			hdr_addr_ff  <= `SFLF_RST_ADDR;
		end else begin
			hdr_valid_ff <= hdr_evt & armed_ff;
			hdr_cmd_ff   <= hdr_evt ? cmd_ff : hdr_cmd_ff;
			hdr_addr_ff  <= hdr_evt ? addr_ff : hdr_addr_ff;
		end
	end
	assign instr_valid       = hdr_valid_ff;
	assign instr_code        = hdr_cmd_ff;
	assign instr_addr        = hdr_addr_ff;
	assign sector_index      = hdr_addr_ff[`SFLF_ARRAY_TOP:`SFLF_SECTOR_LSB];
	assign half_block_index  = hdr_addr_ff[`SFLF_ARRAY_TOP:`SFLF_HALF_LSB];
	assign block_index       = hdr_addr_ff[`SFLF_ARRAY_TOP:`SFLF_BLOCK_LSB];
	assign big_block_index   = hdr_addr_ff[`SFLF_ARRAY_TOP:`SFLF_BIG_LSB];
	assign addr_out_of_range = hdr_addr_ff[`SFLF_ADDR_BITS-1];
	assign instr_addr_lanes  = aw;
	assign instr_data_lanes  = dw;
	assign instr_is_read     = cur_read;

	// written bytes wait in a pending slot while the fifo is full; a newer
	// byte then takes the slot and the older one is lost, because the
	// serial clock cannot be stalled
	wire fifo_ready;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pend_ff      <= 1'b0;
			pend_byte_ff <= `SFLF_RST_BYTE;
			overrun_ff   <= 1'b0;
		end else begin
			pend_ff      <= wb_evt | (pend_ff & ~fifo_ready);
			pend_byte_ff <= wb_evt ? wbyte_ff : pend_byte_ff;
			overrun_ff   <= wb_evt & pend_ff & ~fifo_ready;
		end
	end
	assign wr_overrun = overrun_ff;

	sflf_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock   (clock),
		.rst     (rst),
		.s_valid (pend_ff),
		.s_ready (fifo_ready),
		.s_data  (pend_byte_ff),
		.m_valid (wr_valid),
		.m_ready (wr_ready),
		.m_data  (wr_data)
	);

	// read hold: stable while full, freed when the link takes it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_full_ff <= 1'b0;
			rd_hold_ff <= `SFLF_IDLE_BYTE;
		end else begin
			rd_full_ff <= (rd_valid & ~rd_full_ff) | (rd_full_ff & ~rd_evt);
			rd_hold_ff <= (rd_valid & ~rd_full_ff) ? rd_data : rd_hold_ff;
		end
	end
	assign rd_ready = ~rd_full_ff;

	a_last_sector: assert property (@(posedge clock) disable iff (rst)
		hdr_valid_ff && sector_index == `SFLF_LAST_SECTOR
		|-> hdr_addr_ff[22:12] == 11'h7FF && hdr_addr_ff[11:0] <= 12'hFFF)
		else $error("last sector outside top of array");
	a_half_in_block: assert property (@(posedge clock) disable iff (rst)
		instr_valid |-> half_block_index[7:1] == block_index)
		else $error("half block not inside its block");
	a_big_of_block: assert property (@(posedge clock) disable iff (rst)
		instr_valid |-> big_block_index == block_index[6:4])
		else $error("big block does not hold the block");
	a_quad_needs_qe: assert property (@(posedge clock) disable iff (rst)
		instr_valid && instr_data_lanes == SFLF_W4 |-> quad_enable_bit)
		else $error("quad instruction passed without quad enable");
	a_dual_width: assert property (@(posedge clock) disable iff (rst)
		instr_valid && instr_code == `SFLF_OP_DUAL_OUT
		|-> instr_data_lanes == SFLF_W2 && instr_addr_lanes == SFLF_W1)
		else $error("dual output read with wrong lanes");
	a_arm_after_high: assert property (@(posedge clock) disable iff (rst)
		$rose(armed_ff) |-> $past(seen_ff[0]))
		else $error("armed without chip select seen high");
	a_fail_disarms: assert property (@(posedge clock) disable iff (rst)
		power_fail |=> !armed_ff ##1 !instr_valid)
		else $error("still armed after power failure");
	a_deselect_float: assert property (@(posedge clock) disable iff (rst)
		chip_select_n |-> !data_lane_zero_oe && !data_lane_one_oe
		&& !data_lane_two_oe && !data_lane_three_oe)
		else $error("lane driven while deselected");
	a_quad_lanes: assert property (@(posedge clock) disable iff (rst)
		data_lane_two_oe |-> data_lane_three_oe && data_lane_zero_oe
		&& quad_enable_bit)
		else $error("quad lanes driven apart");
	a_wp_gone_qe: assert property (@(posedge clock) disable iff (rst)
		quad_enable_bit |-> !write_protect_active)
		else $error("write protect active in quad mode");
	c_quad_header: cover property (@(posedge clock) disable iff (rst)
		instr_valid && instr_data_lanes == SFLF_W4);
	c_read_taken: cover property (@(posedge clock) disable iff (rst)
		rd_full_ff ##[1:200] !rd_full_ff);
	c_write_byte: cover property (@(posedge clock) disable iff (rst) wr_valid);
endmodule : sflf_frontend

`default_nettype wire

// ---- sflf_host_model.sv ----
/*
 * serial host model for the lane front end: frames in clock modes 0 and 3
 * on one, two or four lanes, reads with eight dummy clocks.
 * assumes: lane vectors ordered three..zero; serial clock period 64 ns.
 */
`timescale 1ns/1ps
`default_nettype none

module sflf_host_model (
	output logic            serial_clock,
	output logic            chip_select_n,
	output logic      [3:0] lane_level,
	input  wire logic [3:0] lane_drive,
	input  wire logic [3:0] lane_oe
);
	logic [3:0] hv    = 4'h0;
	logic [3:0] he    = 4'h0;
	logic       flip  = 1'b0;
	logic [7:0] rbyte = 8'h00;

	// select sits low from power-up on purpose, so arming can be seen
	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b0;
	end

	// released lanes: pull-ups on two and three, a toggling pattern on
	// zero and one so a stale value never passes for data
	always #8 flip = ~flip;
	assign lane_level = (lane_oe & lane_drive) | (~lane_oe & he & hv)
		| (~lane_oe & ~he & {2'b11, flip, flip});

	// n bits msb first, w per clock; data set while clock low
	task automatic bits(input logic [31:0] v, input int n, input int w,
		input logic rd);
		logic [31:0] t;
		for (int i = n; i > 0; i -= w) begin
			t = v >> (i - w);
			serial_clock = 1'b0;
			he = rd ? 4'h0 : (w == 4 ? 4'hF : w == 2 ? 4'h3 : 4'h1);
			hv = t[3:0];
			#32;
			serial_clock = 1'b1;
			rbyte = (w == 1) ? {rbyte[6:0], lane_level[1]} :
				(w == 2) ? {rbyte[5:0], lane_level[1:0]} :
				{rbyte[3:0], lane_level};
			#32;
		end
	endtask : bits

	// one whole frame; the clock idles at cpol between frames
	task automatic xfer(input logic [7:0] op, input logic [23:0] adr,
		input int aw, input int dw, input int nb, input logic [7:0] wb,
		input logic rd, input logic cpol);
		serial_clock = cpol;
		#64;
		chip_select_n = 1'b0;
		#32;
		bits(op, 8, 1, 1'b0);
		bits(adr, 24, aw, 1'b0);
		if (rd)
			bits(32'h0000_0000, 8, 1, 1'b1);
		for (int k = 0; k < nb; k++)
			bits(wb + k, 8, dw, rd);
		serial_clock = cpol;
		#32;
		he = 4'h0;
		chip_select_n = 1'b1; // deselected between frames
		#200;
	endtask : xfer
endmodule : sflf_host_model

`default_nettype wire

// ---- test_serial_flash_lane_frontend.sv ----
/*
 * bench of the lane front end: reset, arming, geometry, power fail,
 * quad gating, lane widths per opcode and write buffering.
 * assumes: sflf_host_model plays the serial host on the far side.
 */
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_lane_frontend;
	logic        clock = 1'b0, rst = 1'b1, power_fail = 1'b0;
	logic        wr_ready = 1'b1, rd_valid = 1'b0;
	logic [7:0]  ssr = 8'h00, rd_data = 8'h00;
	wire         sck, csn, iv, rd_ready, wr_valid, wr_ovr, ir, oor, wpa;
	wire  [3:0]  lv, dr, oe;
	wire  [7:0]  icode, wdat, halfi;
	wire  [23:0] iaddr;
	wire  [2:0]  al, dl, bigi;
	wire  [10:0] seci;
	wire  [6:0]  blki;
	int          error_cnt = 0, check_count = 0, hdr_cnt = 0;
	int          ovr_cnt = 0, cyc = 0;
	logic [7:0]  wq [$];

	always #12.5 clock = ~clock;

	sflf_frontend #(.FIFO_DEPTH(16)) i_sflf_frontend (
		.clock(clock), .rst(rst), .power_fail(power_fail),
		.second_status_register(ssr), .serial_clock(sck),
		.chip_select_n(csn), .data_lane_zero_level(lv[0]),
		.data_lane_zero_drive(dr[0]), .data_lane_zero_oe(oe[0]),
		.data_lane_one_level(lv[1]), .data_lane_one_drive(dr[1]),
		.data_lane_one_oe(oe[1]), .data_lane_two_level(lv[2]),
		.data_lane_two_drive(dr[2]), .data_lane_two_oe(oe[2]),
		.data_lane_three_level(lv[3]), .data_lane_three_drive(dr[3]),
		.data_lane_three_oe(oe[3]), .write_protect_active(wpa),
		.instr_valid(iv), .instr_code(icode), .instr_addr(iaddr),
		.instr_addr_lanes(al), .instr_data_lanes(dl), .instr_is_read(ir),
		.sector_index(seci), .half_block_index(halfi),
		.block_index(blki), .big_block_index(bigi),
		.addr_out_of_range(oor), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wdat), .wr_overrun(wr_ovr), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data));

	sflf_host_model i_sflf_host_model (.serial_clock(sck),
		.chip_select_n(csn), .lane_level(lv), .lane_drive(dr),
		.lane_oe(oe));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// header, write byte and overrun monitors; a hang ends the run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (iv === 1'b1)
			hdr_cnt <= hdr_cnt + 1;
		if (wr_ovr === 1'b1)
			ovr_cnt <= ovr_cnt + 1;
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			wq.push_back(wdat);
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	// one frame, then the number of headers it gave and floating lanes
	task automatic frame(input logic [7:0] op, input logic [23:0] adr,
		input int aw, dw, nb, input logic [7:0] wb, input logic rd, cpol,
		input int hdr);
		int n0;
		n0 = hdr_cnt;
		i_sflf_host_model.xfer(op, adr, aw, dw, nb, wb, rd, cpol);
		chk(hdr_cnt - n0, hdr);
		chk(oe, 4'h0);
	endtask : frame

	// offer one read byte and hold it until the hold takes it
	task automatic load_rd(input logic [7:0] v);
		@(posedge clock);
		rd_valid <= 1'b1;
		rd_data <= v;
		@(posedge clock);
		while (rd_ready !== 1'b1)
			@(posedge clock);
		rd_valid <= 1'b0;
	endtask : load_rd

	// select low since power-up: the first frame is ignored
	task automatic t_unarmed;
		frame(8'h02, 24'h00_1000, 1, 1, 1, 8'h11, 1'b0, 1'b0, 0);
		chk(wq.size(), 0);
	endtask : t_unarmed

	// last sector, a half block edge and an address above the array
	task automatic t_geom;
		logic [23:0] a [3] = '{24'h7F_F123, 24'h00_8000, 24'h80_0000};
		for (int k = 0; k < 3; k++) begin
			frame(8'h02, a[k], 1, 1, 1, 8'hA5, 1'b0, 1'b0, 1);
			chk(iaddr, a[k]);
			chk(seci, a[k][22:12]);
			chk(halfi, a[k][22:15]);
			chk(blki, a[k][22:16]);
			chk(bigi, a[k][22:20]);
			chk(oor, a[k][23]);
			chk(wq.pop_front(), 8'hA5);
		end
	endtask : t_geom

	// supply fails in mid-frame: nothing reaches the core
	task automatic t_pfail;
		fork
			frame(8'h02, 24'h00_2000, 1, 1, 1, 8'h22, 1'b0, 1'b0, 0);
			begin
				repeat (20) @(posedge clock);
				power_fail <= 1'b1;
			end
		join
		@(posedge clock) power_fail <= 1'b0;
		repeat (8) @(posedge clock);
		chk(wq.size(), 0);
	endtask : t_pfail

	// quad program with quad enable clear is refused, then enable is set
	task automatic t_gate;
		frame(8'h32, 24'h00_3000, 1, 4, 2, 8'h3C, 1'b0, 1'b0, 0);
		chk(wq.size(), 0);
		@(posedge clock) ssr <= 8'h02;
		@(posedge clock);
		chk(wpa, 1'b0);
	endtask : t_gate

	// every lane-choosing opcode; odd entries run in clock mode 3
	task automatic t_widths;
		logic [7:0] op [9] = '{8'h3B, 8'hBB, 8'h92, 8'h6B, 8'hEB, 8'hE7,
			8'h94, 8'h32, 8'h03};
		int aw [9] = '{1, 2, 2, 1, 4, 4, 4, 1, 1};
		int dw [9] = '{2, 2, 2, 4, 4, 4, 4, 4, 1};
		logic [23:0] adr;
		for (int k = 0; k < 9; k++) begin
			adr = 24'h5A_C300 | op[k];
			if (k != 7)
				load_rd(op[k] ^ 8'hFF);
			frame(op[k], adr, aw[k], dw[k], 1, 8'h96, k != 7, k[0], 1);
			chk(icode, op[k]);
			chk(iaddr, adr);
			chk(al, aw[k]);
			chk(dl, dw[k]);
			chk(ir, k != 7);
			if (k == 7)
				chk(wq.pop_front(), 8'h96);
			else
				chk(i_sflf_host_model.rbyte, op[k] ^ 8'hFF);
		end
	endtask : t_widths

	// full buffer: one byte waits, the next takes its slot, then all drain
	task automatic t_fifo;
		int o0;
		wq.delete();
		o0 = ovr_cnt;
		@(posedge clock) wr_ready <= 1'b0;
		frame(8'h32, 24'h00_4000, 1, 4, 18, 8'h40, 1'b0, 1'b0, 1);
		chk(ovr_cnt - o0, 1);
		@(posedge clock) wr_ready <= 1'b1;
		repeat (24) @(posedge clock);
		chk(wq.size(), 17);
		chk(wq[16], 8'h51);
	endtask : t_fifo

	// reset for four cycles, then the scenarios in order
	initial begin
		repeat (2) @(posedge clock);
		chk(oe, 4'h0);
		chk({rd_ready, iv, wr_valid, wr_ovr}, 4'h8);
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_unarmed();
		t_geom();
		t_pfail();
		t_gate();
		t_widths();
		t_fifo();
		wrap_up();
	end
endmodule : test_serial_flash_lane_frontend

`default_nettype wire
